// ==== dv/pci_master_model.sv ====
// Purpose: PCI master issuing target lookups
// Assumes: Same clock as the decoder
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/1ns
module pci_master_model (
	// Clock
	input wire logic                hclk,
	// Request out
	output win_decode_pkg::pci_req_s pci_req
);
	import win_decode_pkg::*;
	initial pci_req = '0;
	task automatic send(input logic [31:0] a, input logic io);
		@(posedge hclk);
		pci_req <= '{valid: 1'b1, addr: a, io_cmd: io};
		@(posedge hclk);
		pci_req <= '{valid: 1'b0, addr: ~a, io_cmd: ~io};
	endtask
endmodule

// ==== dv/pci_to_vme_window_decode_bench.sv ====
// Purpose: Self-checking bench of the window decoder
// Assumes: Zero-wait AHB slave, one-cycle decode
// Notes:   Register and decode model kept in the bench
`timescale 1ns/1ns
module pci_to_vme_window_decode_bench;
	import win_decode_pkg::*;
	logic              hclk = 1'b0;
	logic              hresetn = 1'b0;
	logic              hsel = 1'b0;
	logic [31:0]       haddr = 32'h0000_0000;
	logic [1:0]        htrans = 2'h0;
	logic              hwrite = 1'b0;
	logic [2:0]        hsize = 3'h2;
	logic [31:0]       hwdata = 32'h0000_0000;
	logic [31:0]       hrdata;
	logic              hreadyout;
	logic [1:0]        hresp;
	pci_req_s          pci_req;
	vme_cmd_s          vme_cmd_r;
	logic [31:0]       mdl [logic [11:0]];
	logic [11:0]       regs [9] = '{IMG0_CTRL_OFS, IMG0_WINDOW_BASE, IMG0_WINDOW_BOUND, IMG0_ADDR_OFFSET,
		IMG1_WINDOW_CTRL, IMG1_WINDOW_BASE, IMG1_WINDOW_BOUND, IMG1_ADDR_OFFSET, DECODE_STATUS_OFS};
	logic [2:0]        codes [6] = '{SPACE_A16, SPACE_A24, SPACE_A32, SPACE_CRCSR, SPACE_USER1, SPACE_USER2};
	int                err_total = 0;
	int                checks_done = 0;
	always #25 hclk = ~hclk;
	pci_vme_window_decode dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pci_req(pci_req), .vme_cmd_r(vme_cmd_r));
	pci_master_model u_pm (.hclk(hclk), .pci_req(pci_req));
	// ****
	// Model
	// ****
	function automatic logic [31:0] mask_of(input logic [11:0] a);
		if (a == IMG0_CTRL_OFS || a == IMG1_WINDOW_CTRL)
			return 32'hc0c7_5101;
		if (a == IMG0_WINDOW_BASE || a == IMG0_WINDOW_BOUND || a == IMG0_ADDR_OFFSET)
			return 32'hffff_f000;
		return (a == DECODE_STATUS_OFS) ? 32'h0000_0000 : 32'hffff_0000;
	endfunction
	function automatic void reset_model();
		foreach (regs[i])
			mdl[regs[i]] = (regs[i] == IMG0_CTRL_OFS || regs[i] == IMG1_WINDOW_CTRL) ? {8'h00, VDW_RESET, 22'h0} : 32'h0;
	endfunction
	function automatic vme_cmd_s expect_cmd(input logic [31:0] a, input logic io);
		vme_cmd_s    r;
		logic [31:0] c, m, b, d;
		logic        w;
		r = '0;
		for (int i = 1; i >= 0; i--) begin
			c = mdl[i ? IMG1_WINDOW_CTRL : IMG0_CTRL_OFS];
			m = i ? 32'hffff_0000 : 32'hffff_f000;
			b = mdl[i ? IMG1_WINDOW_BASE : IMG0_WINDOW_BASE];
			d = mdl[i ? IMG1_WINDOW_BOUND : IMG0_WINDOW_BOUND];
			w = c[18:16] == SPACE_A24 || c[18:16] == SPACE_A32;
			if (c[31] && c[0] == io && a >= b && (d == 0 || a < d)) begin
				r.claim = 1'b1;
				r.image_sel = i[0];
				r.vme_addr = ((a & m) + mdl[i ? IMG1_ADDR_OFFSET : IMG0_ADDR_OFFSET]) | (a & ~m);
				r.vme_space = c[18:16];
				r.vme_width = c[23:22];
				r.am_bits = {c[12], c[14]};
				r.blt_allow = w && c[23:22] != WIDTH_D64 && c[8];
				r.mblt_allow = w && c[23:22] == WIDTH_D64;
				r.posted = c[30] && !c[0];
			end
		end
		return r;
	endfunction
	// ****
	// Tasks
	// ****
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			err_total++;
			conclude();
		end
	endtask
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		hwrite <= wr;
		htrans <= HTRANS_NONSEQ;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? d : ~d;
		wait_rdy();
		q = hrdata;
		chk("hresp", HRESP_OKAY, hresp);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
		if (mdl.exists(a))
			mdl[a] = d & mask_of(a);
	endtask
	task automatic rd(input logic [11:0] a);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0000_0000, q);
		chk($sformatf("register %h", a), mdl.exists(a) ? mdl[a] : 32'h0000_0000, q);
	endtask
	task automatic look(input logic [31:0] a, input logic io);
		u_pm.send(a, io);
		#1;
		chk("vme_cmd", expect_cmd(a, io), vme_cmd_r);
	endtask
	// ****
	// Sequence
	// ****
	initial begin
		logic [31:0] b, d, a, c;
		int          i;
		void'($urandom(32'hf297b734));
		reset_model();
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		for (int k = 0; k < 9; k++)
			rd(regs[k]);
		for (int t = 0; t < 12; t++) begin
			for (i = 0; i < 2; i++) begin
				c = $urandom & 32'hc0c7_5101;
				c[18:16] = codes[(t + i) % 6];
				c[23:22] = t[1:0];
				c[31] = (t % 5) != 0;
				b = $urandom & 32'h7fff_ffff;
				d = (t % 3 == 0) ? 32'h0 : b + ($urandom & 32'h000f_ffff) + 32'h0001_0000;
				wr(i ? IMG1_WINDOW_CTRL : IMG0_CTRL_OFS, c);
				wr(i ? IMG1_WINDOW_BASE : IMG0_WINDOW_BASE, b);
				wr(i ? IMG1_WINDOW_BOUND : IMG0_WINDOW_BOUND, d);
				wr(i ? IMG1_ADDR_OFFSET : IMG0_ADDR_OFFSET, $urandom);
			end
			for (int k = 0; k < 8; k++)
				rd(regs[k]);
			for (int k = 0; k < 10; k++) begin
				i = k % 2;
				b = mdl[i ? IMG1_WINDOW_BASE : IMG0_WINDOW_BASE];
				d = mdl[i ? IMG1_WINDOW_BOUND : IMG0_WINDOW_BOUND];
				c = mdl[i ? IMG1_WINDOW_CTRL : IMG0_CTRL_OFS];
				case (k / 2)
					0: a = b;
					1: a = b - 1;
					2: a = d - 1;
					3: a = d;
					default: a = b + ($urandom & 32'h00ff_ffff);
				endcase
				look(a, ($urandom % 4 == 0) ? ~c[0] : c[0]);
			end
			wr(12'h200, $urandom);
			rd(12'h200);
			$display("test %0d done", t);
		end
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		reset_model();
		for (int k = 0; k < 9; k++)
			rd(regs[k]);
		$display("test reset done");
		conclude();
	end
	initial begin
		#5000000;
		err_total++;
		conclude();
	end
endmodule

// ==== dv/win_decode_properties.sv ====
// Purpose: Port checks of the window decoder
// Assumes: One clock, async active-low reset
// Notes:   Bound into every decoder instance
`timescale 1ns/1ns
module win_decode_checker (
	// Clock and reset
	input wire logic                     hclk,
	input wire logic                     hresetn,
	// AHB-Lite
	input wire logic                     hsel,
	input wire logic [31:0]              haddr,
	input wire logic [1:0]               htrans,
	input wire logic                     hwrite,
	input wire logic [2:0]               hsize,
	input wire logic [31:0]              hwdata,
	input wire logic                     hready,
	input wire logic [31:0]              hrdata,
	input wire logic                     hreadyout,
	input wire logic [1:0]               hresp,
	// Decode link
	input wire win_decode_pkg::pci_req_s pci_req,
	input wire win_decode_pkg::vme_cmd_s vme_cmd_r
);
	import win_decode_pkg::*;
	// ****
	// Checks
	// ****
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic wide_sp;
	assign wide_sp = vme_cmd_r.vme_space == SPACE_A24 || vme_cmd_r.vme_space == SPACE_A32;
	sequence s_claim;
		vme_cmd_r.claim;
	endsequence
	sequence s_claim_img0;
		vme_cmd_r.claim && !vme_cmd_r.image_sel;
	endsequence
	sequence s_claim_img1;
		vme_cmd_r.claim && vme_cmd_r.image_sel;
	endsequence
	a_claim_needs_req: assert property (s_claim |-> $past(pci_req.valid))
		else $error("claim without request");
	a_idle_all_zero: assert property (!vme_cmd_r.claim |-> vme_cmd_r == '0)
		else $error("command not zero without claim");
	a_blt_narrow_only: assert property (vme_cmd_r.blt_allow |-> wide_sp && vme_cmd_r.vme_width != WIDTH_D64)
		else $error("block transfer outside A24/A32 narrow");
	a_mblt_wide_space: assert property (s_claim ##0 (wide_sp && vme_cmd_r.vme_width == WIDTH_D64) |-> vme_cmd_r.mblt_allow)
		else $error("64-bit transfer not offered");
	a_io_never_posts: assert property (s_claim ##0 $past(pci_req.io_cmd) |-> !vme_cmd_r.posted)
		else $error("I/O transfer posted");
	a_img0_low_bits: assert property (s_claim_img0 |-> vme_cmd_r.vme_addr[11:0] == $past(pci_req.addr[11:0]))
		else $error("image 0 low address bits changed");
	a_img1_low_bits: assert property (s_claim_img1 |-> vme_cmd_r.vme_addr[15:0] == $past(pci_req.addr[15:0]))
		else $error("image 1 low address bits changed");
	a_space_code_legal: assert property (s_claim |-> vme_cmd_r.vme_space != 3'h3 && vme_cmd_r.vme_space != 3'h4)
		else $error("reserved address space issued");
endmodule
bind pci_vme_window_decode win_decode_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .pci_req(pci_req), .vme_cmd_r(vme_cmd_r));

// ==== rtl/pci_vme_window_decode.sv ====
//
// Purpose: PCI target window decode and VMEbus address translation, images 0 and 1
// Assumes: AHB-Lite register slave, one clock, requests from same-clock logic
// Notes:   Result registered one cycle after a valid request
//
// Function
// R1: Base is lowest claimed address
// R2: Claim when base <= address < bound
// R3: Bound zero means no upper limit
// R4: Base compared at 4K or 64K
// R5: Bound compared at 4K or 64K
// R6: Offset applied at 4K or 64K
// R7: Image 0 bits 31:12 add offset
// R8: Image 1 bits 31:16 add offset
// R9: Enable and posting bits reset zero; image 0 enable resets to IMG0_EN_STRAP instead
// R10: Width field encodes 8/16/32/64, resets 32
// R11: Space field selects six VMEbus spaces
// R12: AM code from program and supervisor bits
// R13: Cycle-type bit permits block transfers, resets zero
// R14: Space-select zero memory, one I/O
// R15: Cycle-type only for A24/A32 narrow widths
// R16: A24/A32 64-bit permits MBLT always
// R17: I/O images never post writes
// R18: Disabled image claims nothing
// R19: Command type must match space select
//
`timescale 1ns/1ns
module pci_vme_window_decode #(
	parameter logic [19:0] IMG0_BASE_STRAP  = 20'h0_0000,
	parameter logic [19:0] IMG0_BOUND_STRAP = 20'h0_0000,
	parameter logic        IMG0_EN_STRAP    = 1'b0,
	parameter logic [2:0]  IMG0_VAS_STRAP   = 3'h0,
	parameter logic        IMG0_LAS_STRAP   = 1'b0
) (
	// Clock and reset
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	// AHB-Lite slave
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic [31:0]                      hrdata,
	output logic                             hreadyout,
	output logic [1:0]                       hresp,
	// PCI request in
	input  wire win_decode_pkg::pci_req_s    pci_req,
	// VMEbus command out
	output win_decode_pkg::vme_cmd_s         vme_cmd_r
);
	import win_decode_pkg::*;

	// ************************************************************
	// Register storage
	// ************************************************************
	img_ctrl_s   img0_ctrl_r;
	img_ctrl_s   img1_ctrl_r;
	logic [31:0] img0_window_base_r;
	logic [31:0] img0_window_bound_r;
	logic [31:0] img0_addr_offset_r;
	logic [31:0] img1_window_base_r;
	logic [31:0] img1_window_bound_r;
	logic [31:0] img1_addr_offset_r;
	logic [31:0] claim_count_r;

	logic        wr_pend_r;
	logic [11:0] wr_addr_r;
	logic [11:0] rd_ofs;
	logic        accept;
	logic [31:0] rd_nxt;

	localparam logic [31:0] MASK_4K  = 32'hffff_f000;
	localparam logic [31:0] MASK_64K = 32'hffff_0000;

	// ************************************************************
	// Bus address phase
	// ************************************************************
	assign accept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	// Read offset decoded in the address phase so data stands in the data phase
	assign rd_ofs = haddr[11:0] & ADDR_OFS_MASK;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
		end else if (hready) begin
			wr_pend_r <= accept && hwrite;
			wr_addr_r <= haddr[11:0] & ADDR_OFS_MASK;
		end
	end

	// ************************************************************
	// Response: zero wait, always OKAY
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end
	end

	// ************************************************************
	// Control pack and unpack
	// ************************************************************
	function automatic logic [31:0] ctrl_to_word(input img_ctrl_s c);
		logic [31:0] w;
		w = REG_ZERO;
		w[CTL_EN_BIT]                  = c.enable;
		w[CTL_POSTED_WRITE_ALLOW_BIT]                = c.posted_write_allow;
		w[CTL_VDW_LSB+1:CTL_VDW_LSB]   = c.vme_max_width;
		w[CTL_VAS_LSB+2:CTL_VAS_LSB]   = c.vme_space_select;
		w[CTL_PGM_BIT]                 = c.program_data_select;
		w[CTL_SUPER_BIT]               = c.supervisor_select;
		w[CTL_VCT_BIT]                 = c.block_cycle_allow;
		w[CTL_LAS_BIT]                 = c.pci_space_select;
		return w;
	endfunction

	function automatic img_ctrl_s word_to_ctrl(input logic [31:0] w);
		img_ctrl_s c;
		c.enable              = w[CTL_EN_BIT];
		c.posted_write_allow  = w[CTL_POSTED_WRITE_ALLOW_BIT];
		c.vme_max_width       = w[CTL_VDW_LSB+1:CTL_VDW_LSB];
		c.vme_space_select    = w[CTL_VAS_LSB+2:CTL_VAS_LSB];
		c.program_data_select = w[CTL_PGM_BIT];
		c.supervisor_select   = w[CTL_SUPER_BIT];
		c.block_cycle_allow   = w[CTL_VCT_BIT];
		c.pci_space_select    = w[CTL_LAS_BIT];
		return c;
	endfunction

	// ************************************************************
	// Image 0 registers
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			img0_ctrl_r.enable              <= IMG0_EN_STRAP;
			img0_ctrl_r.posted_write_allow  <= 1'b0;
			img0_ctrl_r.vme_max_width       <= VDW_RESET;
			img0_ctrl_r.vme_space_select    <= IMG0_VAS_STRAP;
			img0_ctrl_r.program_data_select <= 1'b0;
			img0_ctrl_r.supervisor_select   <= 1'b0;
			img0_ctrl_r.block_cycle_allow   <= 1'b0;
			img0_ctrl_r.pci_space_select    <= IMG0_LAS_STRAP;
			img0_window_base_r              <= {IMG0_BASE_STRAP, 12'h000};
			img0_window_bound_r             <= {IMG0_BOUND_STRAP, 12'h000};
			img0_addr_offset_r              <= REG_ZERO;
		end else if (wr_pend_r) begin
			unique case (wr_addr_r)
				IMG0_CTRL_OFS:     img0_ctrl_r         <= word_to_ctrl(hwdata);
				IMG0_WINDOW_BASE:  img0_window_base_r  <= hwdata & MASK_4K;  // R4
				IMG0_WINDOW_BOUND: img0_window_bound_r <= hwdata & MASK_4K;  // R5
				IMG0_ADDR_OFFSET:  img0_addr_offset_r  <= hwdata & MASK_4K;  // R6
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Image 1 registers
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			img1_ctrl_r.enable              <= 1'b0;       // R9
			img1_ctrl_r.posted_write_allow  <= 1'b0;       // R9
			img1_ctrl_r.vme_max_width       <= VDW_RESET;  // R10
			img1_ctrl_r.vme_space_select    <= SPACE_A16;
			img1_ctrl_r.program_data_select <= 1'b0;
			img1_ctrl_r.supervisor_select   <= 1'b0;
			img1_ctrl_r.block_cycle_allow   <= 1'b0;       // R13
			img1_ctrl_r.pci_space_select    <= 1'b0;
			img1_window_base_r              <= REG_ZERO;
			img1_window_bound_r             <= REG_ZERO;
			img1_addr_offset_r              <= REG_ZERO;
		end else if (wr_pend_r) begin
			unique case (wr_addr_r)
				IMG1_WINDOW_CTRL:  img1_ctrl_r         <= word_to_ctrl(hwdata);
				IMG1_WINDOW_BASE:  img1_window_base_r  <= hwdata & MASK_64K;  // R4
				IMG1_WINDOW_BOUND: img1_window_bound_r <= hwdata & MASK_64K;  // R5
				IMG1_ADDR_OFFSET:  img1_addr_offset_r  <= hwdata & MASK_64K;  // R6
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Read data
	// ************************************************************
	always_comb begin
		rd_nxt = REG_ZERO;
		unique case (rd_ofs)
			IMG0_CTRL_OFS:     rd_nxt = ctrl_to_word(img0_ctrl_r);
			IMG0_WINDOW_BASE:  rd_nxt = img0_window_base_r;
			IMG0_WINDOW_BOUND: rd_nxt = img0_window_bound_r;
			IMG0_ADDR_OFFSET:  rd_nxt = img0_addr_offset_r;
			IMG1_WINDOW_CTRL:  rd_nxt = ctrl_to_word(img1_ctrl_r);
			IMG1_WINDOW_BASE:  rd_nxt = img1_window_base_r;
			IMG1_WINDOW_BOUND: rd_nxt = img1_window_bound_r;
			IMG1_ADDR_OFFSET:  rd_nxt = img1_addr_offset_r;
			DECODE_STATUS_OFS: rd_nxt = claim_count_r;
			default:           rd_nxt = REG_ZERO;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= REG_ZERO;
		end else if (accept && !hwrite) begin
			hrdata <= rd_nxt;
		end
	end

	// ************************************************************
	// Window compare
	// ************************************************************
	logic        img0_in;
	logic        img1_in;
	logic [31:0] img0_vme;
	logic [31:0] img1_vme;
	logic        img0_hit;
	logic        img1_hit;

	win_match #(.GRAIN_LSB(GRAIN_4K_LSB)) u_img0 (
		.window_base  (img0_window_base_r),
		.window_bound (img0_window_bound_r),
		.xlate_offset (img0_addr_offset_r),
		.pci_addr     (pci_req.addr),
		.in_window    (img0_in),
		.vme_addr     (img0_vme)
	);

	win_match #(.GRAIN_LSB(GRAIN_64K_LSB)) u_img1 (
		.window_base  (img1_window_base_r),
		.window_bound (img1_window_bound_r),
		.xlate_offset (img1_addr_offset_r),
		.pci_addr     (pci_req.addr),
		.in_window    (img1_in),
		.vme_addr     (img1_vme)
	);

	// R14 R18 R19
	assign img0_hit = pci_req.valid && img0_ctrl_r.enable && img0_in &&
	                  (pci_req.io_cmd == img0_ctrl_r.pci_space_select);
	assign img1_hit = pci_req.valid && img1_ctrl_r.enable && img1_in &&
	                  (pci_req.io_cmd == img1_ctrl_r.pci_space_select);

	// ************************************************************
	// VMEbus command build
	// ************************************************************
	function automatic vme_cmd_s build_cmd(input img_ctrl_s c, input logic [31:0] a, input logic sel);
		vme_cmd_s v;
		logic     a24_a32;
		logic     wide;
		a24_a32     = (c.vme_space_select == SPACE_A24) || (c.vme_space_select == SPACE_A32);
		wide        = (c.vme_max_width == WIDTH_D64);                 // R10
		v.claim     = 1'b1;
		v.image_sel = sel;
		v.vme_addr  = a;
		v.vme_space = c.vme_space_select;                             // R11
		v.vme_width = c.vme_max_width;                                // R10
		v.am_bits   = {c.supervisor_select, c.program_data_select};   // R12
		v.blt_allow = a24_a32 && !wide && c.block_cycle_allow;        // R13 R15
		v.mblt_allow = a24_a32 && wide;                               // R16
		v.posted    = c.posted_write_allow && !c.pci_space_select;    // R9 R17
		return v;
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vme_cmd_r <= '0;
		end else if (img0_hit) begin
			vme_cmd_r <= build_cmd(img0_ctrl_r, img0_vme, 1'b0);       // R7
		end else if (img1_hit) begin
			vme_cmd_r <= build_cmd(img1_ctrl_r, img1_vme, 1'b1);       // R8
		end else begin
			vme_cmd_r <= '0;                                           // R18
		end
	end

	// ************************************************************
	// Claim counter
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			claim_count_r <= REG_ZERO;
		end else if (img0_hit || img1_hit) begin
			claim_count_r <= claim_count_r + 32'h0000_0001;
		end
	end

endmodule

// ==== rtl/win_decode_pkg.sv ====
//
// Purpose: Shared constants and carriers for the PCI target window decoder
// Assumes: AHB-Lite register access, 32-bit words
// Notes:   Offsets are byte addresses
//
package win_decode_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [11:0] IMG0_CTRL_OFS      = 12'h100;
	localparam logic [11:0] IMG0_WINDOW_BASE   = 12'h104;
	localparam logic [11:0] IMG0_WINDOW_BOUND  = 12'h108;
	localparam logic [11:0] IMG0_ADDR_OFFSET   = 12'h10c;
	localparam logic [11:0] IMG1_WINDOW_CTRL   = 12'h114;
	localparam logic [11:0] IMG1_WINDOW_BASE   = 12'h118;
	localparam logic [11:0] IMG1_WINDOW_BOUND  = 12'h11c;
	localparam logic [11:0] IMG1_ADDR_OFFSET   = 12'h120;
	localparam logic [11:0] DECODE_STATUS_OFS  = 12'h124;
	localparam logic [11:0] ADDR_OFS_MASK      = 12'hffc;

	// ************************************************************
	// Granularity
	// ************************************************************
	localparam int          GRAIN_4K_LSB       = 12;
	localparam int          GRAIN_64K_LSB      = 16;

	// ************************************************************
	// Control register field positions
	// ************************************************************
	localparam int          CTL_EN_BIT         = 31;
	localparam int          CTL_POSTED_WRITE_ALLOW_BIT       = 30;
	localparam int          CTL_VDW_LSB        = 22;
	localparam int          CTL_VAS_LSB        = 16;
	localparam int          CTL_PGM_BIT        = 14;
	localparam int          CTL_SUPER_BIT      = 12;
	localparam int          CTL_VCT_BIT        = 8;
	localparam int          CTL_LAS_BIT        = 0;

	// ************************************************************
	// Field encodings and reset values
	// ************************************************************
	localparam logic [1:0]  WIDTH_D8           = 2'h0;
	localparam logic [1:0]  WIDTH_D16          = 2'h1;
	localparam logic [1:0]  WIDTH_D32          = 2'h2;
	localparam logic [1:0]  WIDTH_D64          = 2'h3;
	localparam logic [1:0]  VDW_RESET          = WIDTH_D32;
	localparam logic [2:0]  SPACE_A16          = 3'h0;
	localparam logic [2:0]  SPACE_A24          = 3'h1;
	localparam logic [2:0]  SPACE_A32          = 3'h2;
	localparam logic [2:0]  SPACE_CRCSR        = 3'h5;
	localparam logic [2:0]  SPACE_USER1        = 3'h6;
	localparam logic [2:0]  SPACE_USER2        = 3'h7;
	localparam logic [31:0] REG_ZERO           = 32'h0000_0000;
	localparam logic [19:0] IMG0_STRAP_DEFAULT = 20'h0_0000;

	// ************************************************************
	// AHB codes
	// ************************************************************
	localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ         = 2'h3;
	localparam logic [1:0]  HRESP_OKAY         = 2'h0;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic        enable;
		logic        posted_write_allow;
		logic [1:0]  vme_max_width;
		logic [2:0]  vme_space_select;
		logic        program_data_select;
		logic        supervisor_select;
		logic        block_cycle_allow;
		logic        pci_space_select;
	} img_ctrl_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        io_cmd;
	} pci_req_s;

	typedef struct packed {
		logic        claim;
		logic        image_sel;
		logic [31:0] vme_addr;
		logic [2:0]  vme_space;
		logic [1:0]  vme_width;
		logic [1:0]  am_bits;
		logic        blt_allow;
		logic        mblt_allow;
		logic        posted;
	} vme_cmd_s;

endpackage

// ==== rtl/win_match.sv ====
//
// Purpose: One window compare and address translation
// Assumes: Registers already masked to the image granularity
// Notes:   Pure combinational; GRAIN_LSB sets 4K or 64K resolution
//
`timescale 1ns/1ns
module win_match #(
	parameter int GRAIN_LSB = 12
) (
	// Window setup
	input  wire logic [31:0] window_base,
	input  wire logic [31:0] window_bound,
	input  wire logic [31:0] xlate_offset,
	// Request
	input  wire logic [31:0] pci_addr,
	// Result
	output logic             in_window,
	output logic [31:0]      vme_addr
);
	localparam int HW = 32 - GRAIN_LSB;

	logic [HW-1:0] addr_hi;
	logic [HW-1:0] base_hi;
	logic [HW-1:0] bound_hi;
	logic [HW-1:0] sum_hi;

	assign addr_hi  = pci_addr[31:GRAIN_LSB];
	assign base_hi  = window_base[31:GRAIN_LSB];   // R1 R4
	assign bound_hi = window_bound[31:GRAIN_LSB];  // R5
	// R2 R3
	assign in_window = (addr_hi >= base_hi) && ((bound_hi == '0) || (addr_hi < bound_hi));
	// R6 R7 R8
	assign sum_hi   = HW'(addr_hi + xlate_offset[31:GRAIN_LSB]);
	assign vme_addr = {sum_hi, pci_addr[GRAIN_LSB-1:0]};
endmodule
